// ### core/pst_defines.svh
// cycle figures and condition codes for the pipeline stall timing block
// assumes single processor clock; every figure below except the two condition codes is a count of clock cycles
// Notes on behaviour
// - non-sequential icache miss stalls five cycles
// - sequential icache miss averages 2.5 cycles
// - dcache miss two cycles, burst three more
// - read after burst miss: three, then two
// - straddling data access costs two cycles
// - straddling non-sequential opcode costs one cycle
// - page change or serializing costs two cycles
// - address extra is pair term plus operands
// - mode cost: relative 3, external 8, scaled 2
// - float adds three plus two per memory long
// - slave transfer: id/opcode or last word
// - finishing interval after slave done signal
// - size selector zero single, one double
// - break zero: address unit continues immediately
// - positive break: wait that many cycles
// - negative break: restart magnitude before end
// - drain waits six/seven, second write two
// - interlocked bit ops drain, then three more
// - branch timing has four outcome classes
// - base time excludes dependency and storage delays
// - predict taken if backward, not-equal or less-equal
// - back-to-back conditional branches cost two cycles
`ifndef PST_DEFINES_SVH
`define PST_DEFINES_SVH
`define PST_IMISS_NONSEQ   8'h05
`define PST_IMISS_SEQ_LO   8'h02
`define PST_IMISS_SEQ_HI   8'h03
`define PST_DMISS          8'h02
`define PST_DMISS_BURST    8'h03
`define PST_FOLLOW_NEXT    8'h03
`define PST_FOLLOW_SECOND  8'h02
`define PST_DATA_STRADDLE  8'h02
`define PST_OPC_STRADDLE   8'h01
`define PST_PAGE_XLATE     8'h02
`define PST_WB_FIRST_FAST  8'h06
`define PST_WB_FIRST_SLOW  8'h07
`define PST_WB_SECOND      8'h02
`define PST_RMW_EXTRA      8'h03
`define PST_B2B_BRANCH     8'h02
`define PST_PAIR_MEM       8'h02
`define PST_MODE_MEMREL    8'h03
`define PST_MODE_EXT       8'h08
`define PST_MODE_SCALED    8'h02
`define PST_FLT_BASE       8'h03
`define PST_FLT_PER_LONG   8'h02
`define PST_XFER_ID_OP     8'h02
`define PST_XFER_LAST32    8'h02
`define PST_FIN_DONE       8'h02
`define PST_FIN_READ_WORD  8'h02
`define PST_COND_NE        4'h1
`define PST_COND_LE        4'hd
`endif

// ### core/pst_pkg.sv
// types and shared decode for the pipeline stall timing block
// assumes pst_defines.svh sits on the include path
`include "pst_defines.svh"
package pst_pkg;
	typedef enum logic [1:0] {
		PST_MODE_OTHER  = 2'b00,
		PST_MODE_MEMREL = 2'b01,
		PST_MODE_EXT    = 2'b10,
		PST_MODE_SCALED = 2'b11
	} pst_mode_type;

	typedef enum logic [1:0] {
		PST_TAKEN_RIGHT     = 2'b00,
		PST_TAKEN_WRONG     = 2'b01,
		PST_NOT_TAKEN_RIGHT = 2'b10,
		PST_NOT_TAKEN_WRONG = 2'b11
	} pst_branch_class_type;

	// address unit cost of one general operand
	function automatic logic [7:0] pst_mode_penalty(input pst_mode_type mode);
		logic [7:0] pen;
		pen = 8'h00;
		unique case (mode)
			PST_MODE_MEMREL: pen = `PST_MODE_MEMREL;
			PST_MODE_EXT:    pen = `PST_MODE_EXT;
			PST_MODE_SCALED: pen = `PST_MODE_SCALED;
			PST_MODE_OTHER:  pen = 8'h00;
		endcase
		return pen;
	endfunction : pst_mode_penalty
endpackage : pst_pkg

// ### core/pst_addr_time.sv
// address unit extra time for general and floating operands
// assumes attributes are steady in the cycle load_i is high
`timescale 1ns/10ps
`include "pst_defines.svh"
module pst_addr_time (
	input  wire logic              clk_sys_i,
	input  wire logic              rst_b_i,
	input  wire logic              load_i,
	input  wire pst_pkg::pst_mode_type op1_mode_i,
	input  wire pst_pkg::pst_mode_type op2_mode_i,
	input  wire logic              two_mem_operands_i,
	input  wire logic              float_i,
	input  wire logic [1:0]        mem64_count_i,
	output logic [7:0]             addr_unit_extra_time_o,
	output logic [7:0]             float_addr_extra_time_o
);
	import pst_pkg::*;

	logic [7:0] operand1_mode_penalty;
	logic [7:0] operand2_mode_penalty;
	logic [7:0] tad_d, tad_q, float_addr_extra_time_d, float_addr_extra_time_q;

	// both terms are computed each load; float term is zero on integer work
	always_comb begin
		operand1_mode_penalty = pst_mode_penalty(op1_mode_i);
		operand2_mode_penalty = pst_mode_penalty(op2_mode_i);
		tad_d  = tad_q;
		float_addr_extra_time_d = float_addr_extra_time_q;
		if (load_i) begin
			tad_d = (two_mem_operands_i ? `PST_PAIR_MEM : 8'h00)
				+ operand1_mode_penalty + operand2_mode_penalty;
			float_addr_extra_time_d = float_i ? 8'(`PST_FLT_BASE + `PST_FLT_PER_LONG * {6'h00, mem64_count_i})
				: 8'h00;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tad_q  <= 8'h00;
			float_addr_extra_time_q <= 8'h00;
		end else begin
			tad_q  <= tad_d;
			float_addr_extra_time_q <= float_addr_extra_time_d;
		end
	end

	assign addr_unit_extra_time_o  = tad_q;
	assign float_addr_extra_time_o = float_addr_extra_time_q;
endmodule : pst_addr_time

// ### core/pst_branch_pred.sv
// static branch prediction, outcome class and back-to-back detection
// assumes one load_i pulse per instruction; outputs are combinational
`timescale 1ns/10ps
`include "pst_defines.svh"
module pst_branch_pred (
	input  wire logic                 clk_sys_i,
	input  wire logic                 rst_b_i,
	input  wire logic                 load_i,
	input  wire logic                 branch_cond_i,
	input  wire logic                 branch_backward_i,
	input  wire logic [3:0]           cond_code_i,
	input  wire logic                 branch_taken_i,
	output logic                      predict_taken_o,
	output pst_pkg::pst_branch_class_type branch_class_o,
	output logic [7:0]                b2b_penalty_o
);
	import pst_pkg::*;

	logic prev_cond_d, prev_cond_q;

	// prediction and outcome class
	always_comb begin
		predict_taken_o = branch_backward_i || cond_code_i == `PST_COND_NE
			|| cond_code_i == `PST_COND_LE;
		unique case ({branch_taken_i, predict_taken_o})
			2'b11: branch_class_o = PST_TAKEN_RIGHT;
			2'b10: branch_class_o = PST_TAKEN_WRONG;
			2'b00: branch_class_o = PST_NOT_TAKEN_RIGHT;
			2'b01: branch_class_o = PST_NOT_TAKEN_WRONG;
		endcase
		// single alternate-stream register: a second conditional waits for it
		b2b_penalty_o = (branch_cond_i && prev_cond_q) ? `PST_B2B_BRANCH : 8'h00;
		prev_cond_d   = load_i ? branch_cond_i : prev_cond_q;
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			prev_cond_q <= 1'b0;
		end else begin
			prev_cond_q <= prev_cond_d;
		end
	end
endmodule : pst_branch_pred

// ### core/pst_stall_timing.sv
// per-instruction stall accounting for a four-stage pipeline
// assumes one instr_valid_i pulse per instruction with its attributes steady
// in that cycle, and that the next pulse waits until stall_o falls
`timescale 1ns/10ps
`include "pst_defines.svh"
module pst_stall_timing (
	input  wire logic              clk_sys_i,
	input  wire logic              rst_b_i,
	input  wire logic              instr_valid_i,
	input  wire logic [7:0]        exec_unit_time_i,
	input  wire logic              icache_miss_i,
	input  wire logic              fetch_seq_i,
	input  wire logic              page_change_i,
	input  wire logic              serialize_i,
	input  wire logic              dcache_miss_i,
	input  wire logic              dcache_burst_i,
	input  wire logic              mem_read_i,
	input  wire logic              data_straddle_i,
	input  wire logic              opcode_straddle_i,
	input  wire logic              wb_drain_i,
	input  wire logic [1:0]        wb_pending_i,
	input  wire logic              wb_first_slow_i,
	input  wire logic              interlocked_bit_op_i,
	input  wire logic              break_valid_i,
	input  wire logic signed [7:0] break_k_i,
	input  wire pst_pkg::pst_mode_type op1_mode_i,
	input  wire pst_pkg::pst_mode_type op2_mode_i,
	input  wire logic              two_mem_operands_i,
	input  wire logic              float_i,
	input  wire logic [1:0]        mem64_count_i,
	input  wire logic              float_operand_i,
	input  wire logic              double_prec_i,
	input  wire logic              slave_done_i,
	input  wire logic              slave_result_i,
	input  wire logic              branch_cond_i,
	input  wire logic              branch_backward_i,
	input  wire logic [3:0]        cond_code_i,
	input  wire logic              branch_taken_i,
	output logic                   stall_o,
	output logic [7:0]             stall_cycles_o,
	output logic [8:0]             eff_time_o,
	output logic [7:0]             addr_unit_extra_time_o,
	output logic [7:0]             float_addr_extra_time_o,
	output logic                   au_hold_o,
	output logic                   size_sel_o,
	output logic [7:0]             cpu_to_slave_transfer_time_o,
	output logic                   finishing_o,
	output logic                   predict_taken_o,
	output pst_pkg::pst_branch_class_type branch_class_o
);
	import pst_pkg::*;

	logic [7:0] c_imiss, c_dmiss, c_follow, c_align, c_page, c_wb, c_b2b, stall_sum;
	logic [7:0] b2b_pen;
	logic       pred_c;
	pst_branch_class_type class_c;

	pst_addr_time u_addr (
		.clk_sys_i               (clk_sys_i),
		.rst_b_i                 (rst_b_i),
		.load_i                  (instr_valid_i),
		.op1_mode_i              (op1_mode_i),
		.op2_mode_i              (op2_mode_i),
		.two_mem_operands_i      (two_mem_operands_i),
		.float_i                 (float_i),
		.mem64_count_i           (mem64_count_i),
		.addr_unit_extra_time_o  (addr_unit_extra_time_o),
		.float_addr_extra_time_o (float_addr_extra_time_o)
	);

	pst_branch_pred u_branch (
		.clk_sys_i         (clk_sys_i),
		.rst_b_i           (rst_b_i),
		.load_i            (instr_valid_i),
		.branch_cond_i     (branch_cond_i),
		.branch_backward_i (branch_backward_i),
		.cond_code_i       (cond_code_i),
		.branch_taken_i    (branch_taken_i),
		.predict_taken_o   (pred_c),
		.branch_class_o    (class_c),
		.b2b_penalty_o     (b2b_pen)
	);

	// history: sequential-miss parity, burst misses one and two back, serialize
	logic half_d, half_q, burst1_d, burst1_q, burst2_d, burst2_q, ser_d, ser_q;

	// stall contributions per source; all add, except that an icache miss masks the page-change cost
	always_comb begin
		if (!icache_miss_i)
			c_imiss = 8'h00;
		else if (!fetch_seq_i)
			c_imiss = `PST_IMISS_NONSEQ;
		else
			c_imiss = half_q ? `PST_IMISS_SEQ_HI : `PST_IMISS_SEQ_LO;
		c_dmiss = dcache_miss_i ? 8'(`PST_DMISS + (dcache_burst_i ? `PST_DMISS_BURST : 8'h00))
			: 8'h00;
		if (mem_read_i && burst1_q)
			c_follow = `PST_FOLLOW_NEXT;
		else if (mem_read_i && burst2_q)
			c_follow = `PST_FOLLOW_SECOND;
		else
			c_follow = 8'h00;
		c_align = (data_straddle_i ? `PST_DATA_STRADDLE : 8'h00)
			+ ((opcode_straddle_i && !fetch_seq_i) ? `PST_OPC_STRADDLE : 8'h00);
		c_page = ((page_change_i && !icache_miss_i) || ser_q) ? `PST_PAGE_XLATE : 8'h00;
		c_wb = 8'h00;
		if (wb_drain_i || interlocked_bit_op_i) begin
			if (wb_pending_i != 2'b00)
				c_wb = wb_first_slow_i ? `PST_WB_FIRST_SLOW : `PST_WB_FIRST_FAST;
			if (wb_pending_i == 2'b10)
				c_wb = c_wb + `PST_WB_SECOND;
		end
		if (interlocked_bit_op_i)
			c_wb = c_wb + `PST_RMW_EXTRA;
		c_b2b = b2b_pen;
		stall_sum = c_imiss + c_dmiss + c_follow + c_align + c_page + c_wb + c_b2b;
		half_d   = half_q;
		burst1_d = burst1_q;
		burst2_d = burst2_q;
		ser_d    = ser_q;
		if (instr_valid_i) begin
			// alternate 2 and 3 so a run of sequential misses averages 2.5
			if (icache_miss_i && fetch_seq_i)
				half_d = !half_q;
			burst1_d = dcache_miss_i && dcache_burst_i;
			burst2_d = burst1_q;
			ser_d    = serialize_i;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			half_q   <= 1'b0;
			burst1_q <= 1'b0;
			burst2_q <= 1'b0;
			ser_q    <= 1'b0;
		end else begin
			half_q   <= half_d;
			burst1_q <= burst1_d;
			burst2_q <= burst2_d;
			ser_q    <= ser_d;
		end
	end

	// stall counter and reported times; base time stays separate from stalls
	logic [7:0] stall_cnt_d, stall_cnt_q, stall_cyc_d, stall_cyc_q;
	logic [8:0] eff_d, eff_q;
	logic       stall_d, stall_q;

	always_comb begin
		stall_cnt_d = (stall_cnt_q != 8'h00) ? stall_cnt_q - 8'h01 : 8'h00;
		stall_cyc_d = stall_cyc_q;
		eff_d       = eff_q;
		if (instr_valid_i) begin
			stall_cnt_d = stall_sum;
			stall_cyc_d = stall_sum;
			eff_d       = {1'b0, exec_unit_time_i} + {1'b0, stall_sum};
		end
		stall_d = stall_cnt_d != 8'h00;
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			stall_cnt_q <= 8'h00;
			stall_cyc_q <= 8'h00;
			eff_q       <= 9'h000;
			stall_q     <= 1'b0;
		end else begin
			stall_cnt_q <= stall_cnt_d;
			stall_cyc_q <= stall_cyc_d;
			eff_q       <= eff_d;
			stall_q     <= stall_d;
		end
	end

	// address unit hold after a pipeline break
	logic [7:0] au_cnt_d, au_cnt_q, k_mag;
	logic       au_hold_d, au_hold_q;

	always_comb begin
		k_mag    = 8'(-break_k_i);
		au_cnt_d = (au_cnt_q != 8'h00) ? au_cnt_q - 8'h01 : 8'h00;
		if (instr_valid_i && break_valid_i) begin
			if (break_k_i == 8'sh00)
				au_cnt_d = 8'h00;
			else if (break_k_i > 8'sh00)
				au_cnt_d = 8'(break_k_i);
			else
				// held from the start, released |k| cycles before the end
				au_cnt_d = (exec_unit_time_i > k_mag) ? exec_unit_time_i - k_mag : 8'h00;
		end
		au_hold_d = au_cnt_d != 8'h00;
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			au_cnt_q  <= 8'h00;
			au_hold_q <= 1'b0;
		end else begin
			au_cnt_q  <= au_cnt_d;
			au_hold_q <= au_hold_d;
		end
	end

	// floating slave transfer, finishing interval and branch report
	logic [7:0] xfer_d, xfer_q, fin_cnt_d, fin_cnt_q;
	logic       size_d, size_q, fin_d, fin_q, pred_q;
	pst_branch_class_type class_q;

	always_comb begin
		size_d = size_q;
		xfer_d = xfer_q;
		if (instr_valid_i && float_i) begin
			size_d = double_prec_i;
			// with operands only the last word is counted here, the rest in exec time
			xfer_d = float_operand_i ? `PST_XFER_LAST32 : `PST_XFER_ID_OP;
		end
		fin_cnt_d = (fin_cnt_q != 8'h00) ? fin_cnt_q - 8'h01 : 8'h00;
		if (slave_done_i)
			fin_cnt_d = `PST_FIN_DONE + (slave_result_i ? (size_q ? 8'(`PST_FIN_READ_WORD * 2)
				: `PST_FIN_READ_WORD) : 8'h00);
		fin_d = fin_cnt_d != 8'h00;
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			size_q    <= 1'b0;
			xfer_q    <= 8'h00;
			fin_cnt_q <= 8'h00;
			fin_q     <= 1'b0;
			pred_q    <= 1'b0;
			class_q   <= PST_TAKEN_RIGHT;
		end else begin
			size_q    <= size_d;
			xfer_q    <= xfer_d;
			fin_cnt_q <= fin_cnt_d;
			fin_q     <= fin_d;
			if (instr_valid_i && branch_cond_i) begin
				pred_q  <= pred_c;
				class_q <= class_c;
			end
		end
	end

	assign stall_o                      = stall_q;
	assign stall_cycles_o               = stall_cyc_q;
	assign eff_time_o                   = eff_q;
	assign au_hold_o                    = au_hold_q;
	assign size_sel_o                   = size_q;
	assign cpu_to_slave_transfer_time_o = xfer_q;
	assign finishing_o                  = fin_q;
	assign predict_taken_o              = pred_q;
	assign branch_class_o               = class_q;

	// check helpers: last sequential-miss penalty and whether the last pulse was a burst miss
	// kept apart from the history flops so the checks do not lean on the logic they guard
	logic [7:0] seq_pen_d, seq_pen_q;
	logic       seq_seen_d, seq_seen_q, bmiss_d, bmiss_q;

	always_comb begin
		seq_pen_d  = seq_pen_q;
		seq_seen_d = seq_seen_q;
		bmiss_d    = bmiss_q;
		if (instr_valid_i) begin
			bmiss_d = dcache_miss_i && dcache_burst_i;
			if (icache_miss_i && fetch_seq_i) begin
				seq_pen_d  = c_imiss;
				seq_seen_d = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			seq_pen_q  <= 8'h00;
			seq_seen_q <= 1'b0;
			bmiss_q    <= 1'b0;
		end else begin
			seq_pen_q  <= seq_pen_d;
			seq_seen_q <= seq_seen_d;
			bmiss_q    <= bmiss_d;
		end
	end

	// checks
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);

	sequence s_issue3;
		instr_valid_i && stall_sum == 8'h03;
	endsequence
	sequence s_break3;
		instr_valid_i && break_valid_i && break_k_i == 8'sh03;
	endsequence

	a_nonseq_miss: assert property (instr_valid_i && icache_miss_i && !fetch_seq_i
		|-> c_imiss == 8'h05) else $error("nonsequential miss not five cycles");
	a_burst_miss: assert property (instr_valid_i && dcache_miss_i && dcache_burst_i
		|-> c_dmiss == 8'h05) else $error("burst data miss not five cycles");
	a_follow_read: assert property (instr_valid_i && mem_read_i && bmiss_q
		|-> c_follow == 8'h03) else $error("read after burst miss not three cycles");
	a_stall_span: assert property (s_issue3 |=> stall_o [*3] ##1 !stall_o)
		else $error("stall length differs from sum");
	a_eff_time: assert property (instr_valid_i |=> eff_time_o ==
		$past({1'b0, exec_unit_time_i}) + {1'b0, stall_cycles_o})
		else $error("effective time not base plus stall");
	a_break_pos: assert property (s_break3 |=> au_hold_o [*3] ##1 !au_hold_o)
		else $error("positive break hold wrong length");
	a_break_zero: assert property (instr_valid_i && break_valid_i && break_k_i == 8'sh00
		|=> !au_hold_o) else $error("zero break held address unit");
	a_size_sel: assert property (instr_valid_i && float_i |=> size_sel_o == $past(double_prec_i))
		else $error("size selector wrong");
	a_wb_two: assert property (instr_valid_i && wb_drain_i && !interlocked_bit_op_i
		&& wb_pending_i == 2'b10 && wb_first_slow_i |-> c_wb == 8'h09)
		else $error("two buffered writes wait wrong");
	a_rmw_cost: assert property (instr_valid_i && interlocked_bit_op_i
		&& wb_pending_i == 2'b00 |-> c_wb == 8'h03) else $error("interlocked op cost wrong");
	a_seq_pair: assert property (instr_valid_i && icache_miss_i && fetch_seq_i && seq_seen_q
		|-> c_imiss + seq_pen_q == 8'h05) else $error("sequential miss average broken");
endmodule : pst_stall_timing

// ### testbench/pst_slave_model.sv
// floating-point slave stand-in: answers a command with a one-cycle done pulse
// assumes the bench raises cmd_go_i for one cycle, changed at the falling edge
`timescale 1ns/10ps
module pst_slave_model (
	input  wire logic       clk_sys_i,
	input  wire logic       cmd_go_i,
	input  wire logic [3:0] delay_i,
	input  wire logic       has_result_i,
	output logic            slave_done_o,
	output logic            slave_result_o
);
	// command taken on the rising edge, answer after delay_i falling edges (1 = prompt)
	// result line shows the inverse outside done so a stale level never passes
	initial begin
		slave_done_o = 1'b0;
		slave_result_o = 1'b0;
		forever begin
			@(posedge clk_sys_i);
			if (cmd_go_i) begin
				repeat (delay_i) @(negedge clk_sys_i);
				slave_done_o = 1'b1;
				slave_result_o = has_result_i;
				@(negedge clk_sys_i);
				slave_done_o = 1'b0;
				slave_result_o = ~has_result_i;
			end
		end
	end
endmodule : pst_slave_model

// ### testbench/pst_stall_timing_tb_top.sv
// self-checking bench for the stall timing block, one task per scenario
// assumes the design's own assertions run inside it; inputs change at falling edges
`timescale 1ns/10ps
module pst_stall_timing_tb_top;
	import pst_pkg::*;
	logic clk_sys_i = 1'b0;
	logic rst_b_i   = 1'b0;
	logic instr_valid_i, icache_miss_i, fetch_seq_i, page_change_i, serialize_i;
	logic dcache_miss_i, dcache_burst_i, mem_read_i, data_straddle_i, opcode_straddle_i;
	logic wb_drain_i, wb_first_slow_i, interlocked_bit_op_i, break_valid_i, float_i;
	logic two_mem_operands_i, float_operand_i, double_prec_i, slave_done_i, slave_result_i;
	logic branch_cond_i, branch_backward_i, branch_taken_i, sl_go, sl_res;
	logic stall_o, au_hold_o, size_sel_o, finishing_o, predict_taken_o;
	logic [7:0] exec_unit_time_i, stall_cycles_o, addr_unit_extra_time_o;
	logic [7:0] float_addr_extra_time_o, cpu_to_slave_transfer_time_o;
	logic [8:0] eff_time_o;
	logic [1:0] wb_pending_i, mem64_count_i;
	logic [3:0] cond_code_i, sl_delay;
	logic signed [7:0] break_k_i;
	pst_mode_type op1_mode_i, op2_mode_i;
	pst_branch_class_type branch_class_o;
	int errors = 0;
	int check_count = 0;
	int au_cnt;

	pst_stall_timing u_pst_stall_timing (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
		.instr_valid_i(instr_valid_i), .exec_unit_time_i(exec_unit_time_i),
		.icache_miss_i(icache_miss_i), .fetch_seq_i(fetch_seq_i), .page_change_i(page_change_i),
		.serialize_i(serialize_i), .dcache_miss_i(dcache_miss_i), .mem_read_i(mem_read_i),
		.dcache_burst_i(dcache_burst_i), .data_straddle_i(data_straddle_i),
		.opcode_straddle_i(opcode_straddle_i), .wb_drain_i(wb_drain_i),
		.wb_pending_i(wb_pending_i), .wb_first_slow_i(wb_first_slow_i),
		.interlocked_bit_op_i(interlocked_bit_op_i), .break_valid_i(break_valid_i),
		.break_k_i(break_k_i), .op1_mode_i(op1_mode_i), .op2_mode_i(op2_mode_i),
		.two_mem_operands_i(two_mem_operands_i), .float_i(float_i),
		.mem64_count_i(mem64_count_i), .float_operand_i(float_operand_i),
		.double_prec_i(double_prec_i), .slave_done_i(slave_done_i),
		.slave_result_i(slave_result_i), .branch_cond_i(branch_cond_i),
		.branch_backward_i(branch_backward_i), .cond_code_i(cond_code_i),
		.branch_taken_i(branch_taken_i), .stall_o(stall_o), .stall_cycles_o(stall_cycles_o),
		.eff_time_o(eff_time_o), .addr_unit_extra_time_o(addr_unit_extra_time_o),
		.float_addr_extra_time_o(float_addr_extra_time_o), .au_hold_o(au_hold_o),
		.size_sel_o(size_sel_o), .cpu_to_slave_transfer_time_o(cpu_to_slave_transfer_time_o),
		.finishing_o(finishing_o), .predict_taken_o(predict_taken_o),
		.branch_class_o(branch_class_o));

	pst_slave_model u_pst_slave_model (.clk_sys_i(clk_sys_i), .cmd_go_i(sl_go),
		.delay_i(sl_delay), .has_result_i(sl_res), .slave_done_o(slave_done_i),
		.slave_result_o(slave_result_i));

	// 250 MHz system clock
	always #2 clk_sys_i = ~clk_sys_i;

	task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
		end
	endtask : chk

	// idle attributes; exec time 4 keeps the effective-time sum meaningful
	task automatic clear();
		{icache_miss_i, fetch_seq_i, page_change_i, serialize_i, dcache_miss_i} = '0;
		{dcache_burst_i, mem_read_i, data_straddle_i, opcode_straddle_i, wb_drain_i} = '0;
		{wb_first_slow_i, interlocked_bit_op_i, break_valid_i, two_mem_operands_i} = '0;
		{float_i, float_operand_i, double_prec_i, branch_cond_i, branch_backward_i} = '0;
		{branch_taken_i, wb_pending_i, mem64_count_i, cond_code_i, break_k_i} = '0;
		exec_unit_time_i = 8'h04;
		op1_mode_i = PST_MODE_OTHER;
		op2_mode_i = PST_MODE_OTHER;
	endtask : clear

	// one instruction pulse; checks the stall sum and how long stall_o stands
	task automatic issue(input logic [7:0] exp);
		int n;
		int sc;
		n = 0;
		sc = 0;
		au_cnt = 0;
		@(negedge clk_sys_i);
		instr_valid_i = 1'b1;
		@(negedge clk_sys_i);
		instr_valid_i = 1'b0;
		chk(9'(stall_cycles_o), 9'(exp), "stall sum");
		chk(eff_time_o, 9'(exec_unit_time_i) + 9'(exp), "effective time");
		clear();
		while ((stall_o === 1'b1 || au_hold_o === 1'b1) && n < 300) begin
			if (stall_o === 1'b1) sc++;
			if (au_hold_o === 1'b1) au_cnt++;
			@(negedge clk_sys_i);
			n++;
		end
		chk(9'(sc), 9'(exp), "stall length");
		@(negedge clk_sys_i);
	endtask : issue

	task automatic t_fetch();
		int mi[10] = '{1, 1, 1, 1, 0, 0, 0, 0, 0, 1};
		int sq[10] = '{0, 1, 1, 0, 0, 0, 0, 0, 1, 0};
		int pg[10] = '{0, 0, 0, 1, 1, 0, 0, 0, 0, 0};
		int op[10] = '{0, 0, 0, 0, 0, 0, 0, 1, 1, 1};
		int ex[10] = '{5, 2, 3, 5, 2, 0, 2, 1, 0, 8};
		for (int i = 0; i < 10; i++) begin
			icache_miss_i = mi[i][0];
			fetch_seq_i = sq[i][0];
			page_change_i = pg[i][0];
			serialize_i = (i == 5);
			opcode_straddle_i = op[i][0];
			data_straddle_i = (i == 9);
			issue(8'(ex[i]));
		end
	endtask : t_fetch

	task automatic t_data();
		int dm[6] = '{1, 1, 0, 0, 1, 0};
		int rd[6] = '{0, 0, 0, 1, 0, 1};
		int ex[6] = '{2, 5, 0, 2, 5, 3};
		for (int i = 0; i < 6; i++) begin
			dcache_miss_i = dm[i][0];
			dcache_burst_i = dm[i][0] && i > 0;
			mem_read_i = rd[i][0];
			issue(8'(ex[i]));
		end
	endtask : t_data

	task automatic t_wbuf();
		int ex[6] = '{6, 7, 8, 9, 3, 10};
		for (int i = 0; i < 6; i++) begin
			wb_drain_i = (i < 4);
			interlocked_bit_op_i = (i >= 4);
			wb_pending_i = (i == 4) ? 2'h0 : ((i == 2 || i == 3) ? 2'h2 : 2'h1);
			wb_first_slow_i = i[0];
			issue(8'(ex[i]));
		end
	endtask : t_wbuf

	// mode costs worked out here, independent of the design's decode
	function automatic int mcost(input int m);
		return (m == 1) ? 3 : ((m == 2) ? 8 : ((m == 3) ? 2 : 0));
	endfunction : mcost

	task automatic t_addr();
		int e;
		for (int i = 0; i < 32; i++) begin
			op1_mode_i = pst_mode_type'(i[1:0]);
			op2_mode_i = pst_mode_type'(i[3:2]);
			two_mem_operands_i = i[4];
			float_i = i[4] ^ i[0];
			mem64_count_i = 2'(i % 3);
			e = (i[4] ? 2 : 0) + mcost(i % 4) + mcost((i / 4) % 4);
			issue(8'h00);
			chk(9'(addr_unit_extra_time_o), 9'(e), "address extra");
			e = (i[4] ^ i[0]) ? 3 + 2 * (i % 3) : 0;
			chk(9'(float_addr_extra_time_o), 9'(e), "float extra");
		end
	endtask : t_addr

	task automatic t_break();
		int kt[4] = '{0, 3, -2, -6};
		int at[4] = '{0, 3, 3, 0};
		for (int i = 0; i < 4; i++) begin
			break_valid_i = 1'b1;
			break_k_i = 8'(kt[i]);
			exec_unit_time_i = 8'h05;
			issue(8'h00);
			chk(9'(au_cnt), 9'(at[i]), "address unit hold");
		end
	endtask : t_break

	// prompt and slow slave answers, with and without a result word
	task automatic t_float();
		int fin[3] = '{2, 4, 6};
		int n;
		int c;
		for (int i = 0; i < 3; i++) begin
			float_i = 1'b1;
			float_operand_i = (i > 0);
			double_prec_i = (i == 2);
			issue(8'h00);
			chk(9'(size_sel_o), 9'(i == 2), "size select");
			chk(9'(cpu_to_slave_transfer_time_o), 9'h002, "transfer time");
			sl_go = 1'b1;
			sl_res = (i > 0);
			sl_delay = 4'(1 + 3 * i);
			@(negedge clk_sys_i);
			sl_go = 1'b0;
			n = 0;
			c = 0;
			while (finishing_o !== 1'b1 && n < 50) begin
				@(negedge clk_sys_i);
				n++;
			end
			while (finishing_o === 1'b1 && c < 50) begin
				@(negedge clk_sys_i);
				c++;
			end
			chk(9'(c), 9'(fin[i]), "finishing length");
		end
	endtask : t_float

	task automatic t_branch();
		int bk[5] = '{1, 0, 0, 0, 0};
		int cc[5] = '{0, 1, 13, 0, 0};
		int tk[5] = '{1, 0, 1, 1, 0};
		int pr[5] = '{1, 1, 1, 0, 0};
		int cl[5] = '{0, 3, 0, 1, 2};
		issue(8'h00);
		for (int i = 0; i < 5; i++) begin
			branch_cond_i = 1'b1;
			branch_backward_i = bk[i][0];
			cond_code_i = 4'(cc[i]);
			branch_taken_i = tk[i][0];
			issue((i == 0) ? 8'h00 : 8'h02);
			chk(9'(predict_taken_o), 9'(pr[i]), "prediction");
			chk(9'(branch_class_o), 9'(cl[i]), "branch class");
		end
	endtask : t_branch

	task automatic finish_test();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finish_test

	// main sequence: reset for 8 cycles, then every scenario
	initial begin
		instr_valid_i = 1'b0;
		clear();
		{sl_go, sl_res} = 2'h0;
		sl_delay = 4'h1;
		repeat (8) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		chk(9'(stall_cycles_o), 9'h000, "reset value");
		rst_b_i = 1'b1;
		t_fetch();
		t_data();
		t_wbuf();
		t_addr();
		t_break();
		t_float();
		t_branch();
		finish_test();
	end

	// watchdog well beyond the few hundred cycles the scenarios need
	initial begin
		repeat (20000) @(posedge clk_sys_i);
		errors++;
		$display("[FAIL] %0t watchdog expired", $time);
		finish_test();
	end
endmodule : pst_stall_timing_tb_top
